// ---- hw/irq_capture.sv ----
/*
  per-line request capture: pulse latches, software trigger latches, pending
  vector; assumes request lines synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_capture #(parameter int N = irq_pkg::NUM_IRQ) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [N-1:0] lines,
  input wire logic [N-1:0] pulseSel,
  input wire logic [N-1:0] swSet,
  input wire logic [N-1:0] taken,
  irq_req_if.capture req
);
  import irq_pkg::*;
  logic [N-1:0] linePrev;
  logic [N-1:0] pulseHeld;
  logic [N-1:0] swHeld;
  logic [N-1:0] next_linePrev;
  logic [N-1:0] next_pulseHeld;
  logic [N-1:0] next_swHeld;
  wire [N-1:0] pendBits;

  // latch rising edges and triggers; a new set wins over the take clear
  always_comb begin
    next_linePrev = lines;
    next_pulseHeld = (pulseHeld & ~taken) | (lines & ~linePrev & pulseSel);
    next_swHeld = (swHeld & ~taken) | swSet;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      linePrev <= '0;
      pulseHeld <= '0;
      swHeld <= '0;
    end else begin
      linePrev <= next_linePrev;
      pulseHeld <= next_pulseHeld;
      swHeld <= next_swHeld;
    end
  end

  // per line pending: only lines 3 and up can request
  for (genvar i = 0; i < N; i++) begin : g_line
    if (i < FIRST_IRQ) begin : g_none
      assign pendBits[i] = 1'b0;
    end else begin : g_req
      assign pendBits[i] = (pulseSel[i] ? pulseHeld[i] : lines[i]) | swHeld[i];
    end
  end
  assign req.pend = pendBits;
endmodule : irq_capture
`default_nettype wire

// ---- hw/irq_pick.sv ----
/*
  fixed-priority selector for each priority set; purely combinational,
  assumes the pending, mask and set vectors are stable within a cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_pick #(parameter int N = irq_pkg::NUM_IRQ) (
  irq_req_if.pick req
);
  import irq_pkg::*;
  logic [N-1:0] cand1;
  logic [N-1:0] cand2;

  // the highest numbered enabled request of each set wins
  always_comb begin
    cand1 = req.pend & req.mask & ~req.lvl2Sel;
    cand2 = req.pend & req.mask & req.lvl2Sel;
    req.hit1 = |cand1;
    req.hit2 = |cand2;
    req.num1 = '0;
    req.num2 = '0;
    for (int i = 0; i < N; i++) begin
      if (cand1[i]) begin
        req.num1 = IRQ_NUM_W'(i);
      end
      if (cand2[i]) begin
        req.num2 = IRQ_NUM_W'(i);
      end
    end
  end
endmodule : irq_pick
`default_nettype wire

// ---- hw/two_level_interrupt_unit.sv ----
/*
  two-level interrupt unit: AXI4-Lite registers, entry and return sequencing;
  assumes core holds are synchronous levels and return strobes are synchronous one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module two_level_interrupt_unit #(
  parameter logic [31:0] VEC_BUILD = irq_pkg::VECBASE_BUILD,
  parameter bit HAS_BTA = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [irq_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [irq_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [irq_pkg::NUM_IRQ-1:0] irqLine,
  input wire logic memError,
  input wire logic holdCompound,
  input wire logic holdPredBranch,
  input wire logic [31:0] pcNow,
  input wire logic [31:0] btaNow,
  input wire logic returnReq,
  input wire logic flagJumpReq,
  input wire logic flagJumpLevel2,
  input wire logic hostTrigValid,
  input wire logic [irq_pkg::IRQ_NUM_W-1:0] hostTrigNum,
  output logic takeValid,
  output logic takeLevel2,
  output logic [31:0] takeVector,
  output logic returnValid,
  output logic [31:0] returnPc,
  output logic [31:0] returnBta,
  output logic [31:0] statusWord
);
  import irq_pkg::*;

  // ********************************
  // state and request bundle
  // ********************************
  irq_req_if #(.N(NUM_IRQ)) req ();
  logic [31:0] mask, lvl2Sel, sens, vecBase, status, saved1, saved2;
  logic [31:0] link1, link2, sbt1, sbt2;
  logic [1:0] sticky;
  logic [4:0] cause1, cause2, hint;
  logic flagBusy, memPend;
  logic [31:0] next_mask, next_lvl2Sel, next_sens, next_vecBase;
  logic [31:0] next_status, next_saved1, next_saved2;
  logic [31:0] next_link1, next_link2, next_sbt1, next_sbt2;
  logic [1:0] next_sticky;
  logic [4:0] next_cause1, next_cause2, next_hint;
  logic next_flagBusy, next_memPend;
  logic next_takeValid, next_takeLevel2, next_returnValid;
  logic [31:0] next_takeVector, next_returnPc, next_returnBta;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wrGo, rdGo, wrOk, rdOk, statusWr, hold, retDo, retL2;
  logic memTake, take1, take2;
  logic [4:0] takeNum;
  logic [NUM_IRQ-1:0] swSet, taken;
  logic [31:0] rdVal;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        old[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return old;
  endfunction : merge

  assign req.mask = mask;
  assign req.lvl2Sel = lvl2Sel;

  irq_capture #(.N(NUM_IRQ)) u_capture (
    .clk(clk),
    .rstn(rstn),
    .lines(irqLine),
    .pulseSel(sens),
    .swSet(swSet),
    .taken(taken),
    .req(req)
  );

  irq_pick #(.N(NUM_IRQ)) u_pick (
    .req(req)
  );

  // ********************************
  // bus handshake and read mux
  // ********************************
  // write address and data are taken together, one at a time
  assign wrGo = awvalid & wvalid & ~bvalid;
  assign awready = wrGo;
  assign wready = wrGo;
  assign rdGo = arvalid & ~rvalid;
  assign arready = rdGo;
  assign statusWr = wrGo & (awaddr == OFS_STATUS);

  // writable offsets
  always_comb begin
    unique case (awaddr)
      OFS_MASK, OFS_PRIO, OFS_STICKY, OFS_STATUS, OFS_SAVED1, OFS_SAVED2,
      OFS_TRIGGER, OFS_VECBASE, OFS_SENS: wrOk = 1'b1;
      default: wrOk = 1'b0;
    endcase
  end

  // readable offsets; pending is read-only
  always_comb begin
    rdOk = 1'b1;
    unique case (araddr)
      OFS_MASK: rdVal = mask;
      OFS_PRIO: rdVal = lvl2Sel;
      OFS_STICKY: rdVal = {30'h0, sticky};
      OFS_STATUS: rdVal = status;
      OFS_SAVED1: rdVal = saved1;
      OFS_SAVED2: rdVal = saved2;
      OFS_CAUSE1: rdVal = {27'h0, cause1};
      OFS_CAUSE2: rdVal = {27'h0, cause2};
      OFS_PENDING: rdVal = req.pend;
      OFS_TRIGGER: rdVal = {27'h0, hint};
      OFS_VECBASE: rdVal = vecBase;
      OFS_SENS: rdVal = sens;
      default: begin
        rdVal = '0;
        rdOk = 1'b0;
      end
    endcase
  end

  // ********************************
  // entry and return decisions
  // ********************************
  // entry waits for compound instructions, predicted branches, flag updates
  always_comb begin
    hold = holdCompound | holdPredBranch | flagBusy | statusWr;
    retDo = returnReq | flagJumpReq;
    retL2 = flagJumpReq ? flagJumpLevel2 : status[ST_A2];
    memTake = memPend & ~status[ST_A2] & ~hold & ~retDo;
    take2 = ~memTake & req.hit2 & status[ST_E2] & ~status[ST_A2]
            & ~hold & ~retDo;
    take1 = ~memTake & ~take2 & req.hit1 & status[ST_E1]
            & ~status[ST_A1] & ~status[ST_A2] & ~hold & ~retDo;
    takeNum = memTake ? MEMERR_VEC : (take2 ? req.num2 : req.num1);
    taken = '0;
    if (take1 | take2) begin
      taken[takeNum] = 1'b1;
    end
    swSet = '0;
    if (hostTrigValid && hostTrigNum >= IRQ_NUM_W'(FIRST_IRQ)) begin
      swSet[hostTrigNum] = 1'b1;
    end
    if (wrGo && awaddr == OFS_TRIGGER && wstrb[0]
        && wdata[4:0] >= IRQ_NUM_W'(FIRST_IRQ)) begin
      swSet[wdata[4:0]] = 1'b1;
    end
  end

  // ********************************
  // register next values
  // ********************************
  always_comb begin
    next_mask = mask;
    next_lvl2Sel = lvl2Sel;
    next_sens = sens;
    next_vecBase = vecBase;
    next_status = status;
    next_saved1 = saved1;
    next_saved2 = saved2;
    next_link1 = link1;
    next_link2 = link2;
    next_sbt1 = sbt1;
    next_sbt2 = sbt2;
    next_sticky = sticky;
    next_cause1 = cause1;
    next_cause2 = cause2;
    next_hint = hint;
    next_flagBusy = statusWr;
    next_memPend = memPend | memError;
    next_takeValid = 1'b0;
    next_takeLevel2 = takeLevel2;
    next_takeVector = takeVector;
    next_returnValid = 1'b0;
    next_returnPc = returnPc;
    next_returnBta = returnBta;
    // software writes
    if (wrGo) begin
      unique case (awaddr)
        OFS_MASK: next_mask = merge(mask, wdata, wstrb);
        OFS_PRIO: next_lvl2Sel = merge(lvl2Sel, wdata, wstrb);
        OFS_STICKY: next_sticky = sticky & ~(wdata[1:0] & {2{wstrb[0]}});
        OFS_STATUS: next_status = (status & ~ST_EN_MASK)
                                  | (merge(status, wdata, wstrb) & ST_EN_MASK);
        OFS_SAVED1: next_saved1 = merge(saved1, wdata, wstrb) & ST_ALL_MASK;
        OFS_SAVED2: next_saved2 = merge(saved2, wdata, wstrb) & ST_ALL_MASK;
        OFS_TRIGGER: next_hint = wstrb[0] ? wdata[4:0] : hint;
        OFS_VECBASE: next_vecBase = merge(vecBase, wdata, wstrb);
        OFS_SENS: next_sens = merge(sens, wdata, wstrb);
        default: next_hint = hint;
      endcase
    end
    if (hostTrigValid && !(wrGo && awaddr == OFS_TRIGGER)) begin
      next_hint = hostTrigNum;
    end
    // a new trigger number in the same cycle wins over the take clear
    if ((take1 | take2) && hint == takeNum && !hostTrigValid
        && !(wrGo && awaddr == OFS_TRIGGER)) begin
      next_hint = '0;
    end
    // level two entry, memory error included
    if (memTake | take2) begin
      next_saved2 = status;
      next_link2 = pcNow;
      next_sbt2 = btaNow;
      next_status[ST_E1] = 1'b0;
      next_status[ST_E2] = 1'b0;
      next_status[ST_A2] = 1'b1;
      next_cause2 = takeNum;
      next_sticky[1] = 1'b1;
      next_memPend = memError;
    end
    // level one entry
    if (take1) begin
      next_saved1 = status;
      next_link1 = pcNow;
      next_sbt1 = btaNow;
      next_status[ST_E1] = 1'b0;
      next_status[ST_A1] = 1'b1;
      next_cause1 = takeNum;
      next_sticky[0] = 1'b1;
    end
    if (memTake | take1 | take2) begin
      next_takeValid = 1'b1;
      next_takeLevel2 = memTake | take2;
      next_takeVector = vecBase + (32'(takeNum) << VEC_SHIFT);
    end
    // return restores status, link and branch target, causes untouched
    if (retDo) begin
      next_returnValid = 1'b1;
      next_status = retL2 ? saved2 : saved1;
      next_returnPc = retL2 ? link2 : link1;
      next_returnBta = HAS_BTA ? (retL2 ? sbt2 : sbt1) : '0;
    end
  end

  // bus answer registers
  always_comb begin
    next_bvalid = bvalid & ~bready;
    next_bresp = bresp;
    next_rvalid = rvalid & ~rready;
    next_rresp = rresp;
    next_rdata = rdata;
    if (wrGo) begin
      next_bvalid = 1'b1;
      next_bresp = wrOk ? RESP_OKAY : RESP_SLVERR;
    end
    if (rdGo) begin
      next_rvalid = 1'b1;
      next_rresp = rdOk ? RESP_OKAY : RESP_SLVERR;
      next_rdata = rdVal;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mask <= '0;
      lvl2Sel <= PRIO_RST;
      sens <= SENS_RST;
      vecBase <= VEC_BUILD;
      status <= STATUS_RST;
      saved1 <= '0;
      saved2 <= '0;
      link1 <= '0;
      link2 <= '0;
      sbt1 <= '0;
      sbt2 <= '0;
      sticky <= '0;
      cause1 <= '0;
      cause2 <= '0;
      hint <= '0;
      flagBusy <= 1'b0;
      memPend <= 1'b0;
      takeValid <= 1'b0;
      takeLevel2 <= 1'b0;
      takeVector <= '0;
      returnValid <= 1'b0;
      returnPc <= '0;
      returnBta <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= '0;
    end else begin
      mask <= next_mask;
      lvl2Sel <= next_lvl2Sel;
      sens <= next_sens;
      vecBase <= next_vecBase;
      status <= next_status;
      saved1 <= next_saved1;
      saved2 <= next_saved2;
      link1 <= next_link1;
      link2 <= next_link2;
      sbt1 <= next_sbt1;
      sbt2 <= next_sbt2;
      sticky <= next_sticky;
      cause1 <= next_cause1;
      cause2 <= next_cause2;
      hint <= next_hint;
      flagBusy <= next_flagBusy;
      memPend <= next_memPend;
      takeValid <= next_takeValid;
      takeLevel2 <= next_takeLevel2;
      takeVector <= next_takeVector;
      returnValid <= next_returnValid;
      returnPc <= next_returnPc;
      returnBta <= next_returnBta;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  assign statusWord = status;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_entry_two: assert property (take2 |=> takeValid && takeLevel2
      && !status[ST_E1] && !status[ST_E2] && status[ST_A2])
    else $error("level two entry did not clear both enables");
  a_entry_one: assert property (take1 |=> takeValid && !status[ST_E1]
      && status[ST_A1] && sticky[0])
    else $error("level one entry flags wrong");
  a_vector_addr: assert property ((take1 | take2) |=>
      takeVector == $past(vecBase) + {$past(takeNum), 3'h0})
    else $error("handler address wrong");
  a_both_off: assert property (!status[ST_E1] && !status[ST_E2] && !memPend
      |=> !takeValid)
    else $error("interrupt taken with both enables off");
  a_gate_one: assert property (take1 |-> status[ST_E1])
    else $error("level one taken while disabled");
  a_cause_kept: assert property (retDo |=> $stable(cause1) && $stable(cause2))
    else $error("return changed a cause register");
  a_mem_cause: assert property (memTake |=> cause2 == MEMERR_VEC && status[ST_A2])
    else $error("memory error cause wrong");
  a_defer_hold: assert property ((holdCompound || holdPredBranch)
      |-> !take1 && !take2 && !memTake)
    else $error("entry during hold");
  a_defer_flag: assert property (statusWr |-> !take1 ##1 !take1 && !take2)
    else $error("entry during flag update");
  a_ret_restore: assert property (retDo && retL2 |=> returnValid
      && status == $past(saved2) && returnPc == $past(link2))
    else $error("return did not restore level two");
  a_ret_bta: assert property (retDo && !retL2 |=> returnBta == (HAS_BTA ? $past(sbt1) : 32'h0))
    else $error("branch target not restored");
  a_sticky_hold: assert property (sticky[1] && !(wrGo && awaddr == OFS_STICKY)
      |=> sticky[1])
    else $error("sticky bit lost");
  a_reset_vals: assert property ($rose(rstn) |-> lvl2Sel == PRIO_RST
      && vecBase == VEC_BUILD)
    else $error("reset defaults wrong");
  a_bus_answer: assert property (wrGo |=> bvalid)
    else $error("write not answered");

  c_preempt: cover property (status[ST_A1] && take2);
  c_return_two: cover property (returnReq && status[ST_A2]);
  c_mem_error: cover property (memTake);
  c_sw_trigger: cover property (hostTrigValid ##[1:4] takeValid);
endmodule : two_level_interrupt_unit
`default_nettype wire

// ---- include/irq_pkg.sv ----
/*
  constants of the two-level interrupt unit: register offsets, field positions,
  reset values and widths; assumes a 32-bit AXI4-Lite register bus.
*/
package irq_pkg;
  localparam int NUM_IRQ = 32;
  localparam int FIRST_IRQ = 3;
  localparam int IRQ_NUM_W = 5;
  localparam int ADDR_W = 8;
  localparam int VEC_SHIFT = 3;
  localparam logic [4:0] MEMERR_VEC = 5'h1;
  // register byte offsets
  localparam logic [7:0] OFS_MASK = 8'h00;
  localparam logic [7:0] OFS_PRIO = 8'h04;
  localparam logic [7:0] OFS_STICKY = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_SAVED1 = 8'h10;
  localparam logic [7:0] OFS_SAVED2 = 8'h14;
  localparam logic [7:0] OFS_CAUSE1 = 8'h18;
  localparam logic [7:0] OFS_CAUSE2 = 8'h1C;
  localparam logic [7:0] OFS_PENDING = 8'h20;
  localparam logic [7:0] OFS_TRIGGER = 8'h24;
  localparam logic [7:0] OFS_VECBASE = 8'h28;
  localparam logic [7:0] OFS_SENS = 8'h2C;
  // status word fields
  localparam int ST_E1 = 1;
  localparam int ST_E2 = 2;
  localparam int ST_A1 = 3;
  localparam int ST_A2 = 4;
  localparam logic [31:0] ST_EN_MASK = 32'h0000_0006;
  localparam logic [31:0] ST_ALL_MASK = 32'h0000_001E;
  // reset values
  localparam logic [31:0] PRIO_RST = 32'h0000_00C0;
  localparam logic [31:0] SENS_RST = 32'h0000_0000;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] VECBASE_BUILD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : irq_pkg

// ---- include/irq_req_if.sv ----
/*
  request bundle between the capture stage, the selector and the unit core;
  assumes one clock and all members driven by exactly one module.
*/
`timescale 1ns/1ps
`default_nettype none
interface irq_req_if #(parameter int N = 32);
  logic [N-1:0] pend;
  logic [N-1:0] lvl2Sel;
  logic [N-1:0] mask;
  logic hit1;
  logic hit2;
  logic [$clog2(N)-1:0] num1;
  logic [$clog2(N)-1:0] num2;
  modport capture (output pend);
  modport pick (input pend, lvl2Sel, mask, output hit1, hit2, num1, num2);
  modport core (input pend, hit1, hit2, num1, num2, output lvl2Sel, mask);
endinterface : irq_req_if
`default_nettype wire

// ---- sim/irq_peripheral.sv ----
/*
  behavioural peripheral set that drives the request lines.
  assumes raise and drop are one-cycle strobes from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_peripheral (
  input wire logic clk,
  input wire logic rstn,
  input wire logic raise,
  input wire logic asPulse,
  input wire logic [4:0] num,
  input wire logic drop,
  output logic [31:0] lines
);
  logic [31:0] held;
  logic [31:0] pulse;
  // level requests stay up until dropped, pulses last one cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      held <= 32'h0000_0000;
      pulse <= 32'h0000_0000;
    end else begin
      pulse <= (raise && asPulse) ? (32'h0000_0001 << num) : 32'h0000_0000;
      if (raise && !asPulse) held <= held | (32'h0000_0001 << num);
      if (drop) held <= held & ~(32'h0000_0001 << num);
    end
  end
  assign lines = held | pulse;
endmodule : irq_peripheral
`default_nettype wire

// ---- sim/tb_top.sv ----
/*
  self-checking bench: bus tasks note expected results in queues,
  a monitor compares them. assumes the unit answers within the timeout.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import irq_pkg::*;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
  logic awready, wready, arready, memError, holdCompound, holdPredBranch;
  logic returnReq, flagJumpReq, flagJumpLevel2, hostTrigValid;
  logic takeValid, takeLevel2, returnValid, raise, asPulse, drop;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, pcNow, btaNow, takeVector, returnPc, returnBta;
  logic [31:0] statusWord, irqLine, base, retSt;
  logic [1:0] expB[$];
  logic [1:0] expRr[$];
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [4:0] hostTrigNum, reqNum;
  logic [31:0] expRd[$];
  logic [32:0] expTake[$];
  int failures, testsRun, cycles;

  two_level_interrupt_unit dut (
    .clk, .rstn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .irqLine, .memError, .holdCompound, .holdPredBranch,
    .pcNow, .btaNow, .returnReq, .flagJumpReq, .flagJumpLevel2, .hostTrigValid,
    .hostTrigNum, .takeValid, .takeLevel2, .takeVector, .returnValid,
    .returnPc, .returnBta, .statusWord
  );
  irq_peripheral periph (
    .clk, .rstn, .raise, .asPulse, .num(reqNum), .drop, .lines(irqLine)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  task automatic chk(string n, logic [32:0] e, logic [32:0] g);
    testsRun++;
    if (e !== g) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    expB.push_back(r);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [31:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    expRd.push_back(e);
    expRr.push_back(a > OFS_SENS ? RESP_SLVERR : RESP_OKAY);
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd

  task automatic fire(logic [4:0] n, logic p, logic d);
    reqNum <= n;
    asPulse <= p;
    raise <= !d;
    drop <= d;
    @(posedge clk);
    raise <= 1'b0;
    drop <= 1'b0;
  endtask : fire

  // wait up to 40 cycles until every noted entry was seen
  task automatic waitq();
    repeat (40) begin
      if (expTake.size() != 0) @(posedge clk);
    end
    if (expTake.size() != 0) begin
      chk("entries left", 33'h0, 33'(expTake.size()));
      expTake.delete();
    end
  endtask : waitq

  // leave a handler through saved copy s, by flag jump or plain return
  task automatic ret(logic [7:0] ofs, logic [31:0] s, logic fj);
    wr(ofs, s, RESP_OKAY);
    retSt <= s;
    flagJumpLevel2 <= (ofs == OFS_SAVED2);
    flagJumpReq <= fj;
    returnReq <= !fj;
    @(posedge clk);
    flagJumpReq <= 1'b0;
    returnReq <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : ret

  // ****************************************
  // clock, monitor and timeout
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // compare each answer with the oldest note and cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      chk("rdata", expRd.size() ? expRd.pop_front() : ~rdata, rdata);
      chk("rresp", expRr.size() ? expRr.pop_front() : ~rresp, rresp);
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      chk("bresp", expB.size() ? expB.pop_front() : ~bresp, bresp);
    end
    if (takeValid === 1'b1) begin
      chk("entry", expTake.size() ? expTake.pop_front() : ~{takeLevel2, takeVector}, {takeLevel2, takeVector});
    end
    if (returnValid === 1'b1) begin
      chk("statusWord", retSt, statusWord);
      chk("returnPc", pcNow, returnPc);
      chk("returnBta", btaNow, returnBta);
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, memError} = '0;
    {holdCompound, holdPredBranch, returnReq, flagJumpReq, flagJumpLevel2} = '0;
    {hostTrigValid, raise, asPulse, drop, hostTrigNum, reqNum} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    pcNow = $urandom(32'h33a5_ed75);
    btaNow = $urandom;
    base = $urandom & 32'hFFFF_FF00;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(OFS_PRIO, PRIO_RST);
    rd(OFS_SENS, SENS_RST);
    rd(OFS_VECBASE, VECBASE_BUILD);
    rd(8'h40, 32'h0000_0000);
    wr(8'h40, 32'h0000_0000, RESP_SLVERR);
    wr(OFS_PENDING, 32'h0000_0001, RESP_SLVERR);
    wr(OFS_VECBASE, base, RESP_OKAY);
    wr(OFS_MASK, 32'hFFFF_FFD8, RESP_OKAY);
    wr(OFS_TRIGGER, 32'h0000_0009, RESP_OKAY);
    wr(OFS_TRIGGER, 32'h0000_0014, RESP_OKAY);
    repeat (5) @(posedge clk);
    rd(OFS_PENDING, 32'h0010_0200);
    expTake.push_back({1'b0, base + 32'h0000_00A0});
    wr(OFS_STATUS, 32'h0000_0006, RESP_OKAY);
    waitq();
    rd(OFS_STATUS, 32'h0000_000C);
    rd(OFS_CAUSE1, 32'h0000_0014);
    expTake.push_back({1'b0, base + 32'h0000_0048});
    ret(OFS_SAVED1, 32'h0000_0006, 1'b1);
    waitq();
    ret(OFS_SAVED1, 32'h0000_0006, 1'b0);
    fire(5'd5, 1'b0, 1'b0);
    repeat (5) @(posedge clk);
    expTake.push_back({1'b0, base + 32'h0000_0028});
    wr(OFS_MASK, 32'hFFFF_FFF8, RESP_OKAY);
    waitq();
    expTake.push_back({1'b1, base + 32'h0000_0038});
    fire(5'd7, 1'b0, 1'b0);
    waitq();
    rd(OFS_STATUS, 32'h0000_0018);
    rd(OFS_STICKY, 32'h0000_0003);
    fire(5'd7, 1'b0, 1'b1);
    ret(OFS_SAVED2, 32'h0000_000C, 1'b0);
    rd(OFS_STATUS, 32'h0000_000C);
    fire(5'd5, 1'b0, 1'b1);
    ret(OFS_SAVED1, 32'h0000_0006, 1'b0);
    rd(OFS_CAUSE1, 32'h0000_0005);
    rd(OFS_CAUSE2, 32'h0000_0007);
    wr(OFS_STICKY, 32'h0000_0003, RESP_OKAY);
    rd(OFS_STICKY, 32'h0000_0000);
    expTake.push_back({1'b1, base + 32'h0000_0008});
    memError <= 1'b1;
    @(posedge clk);
    memError <= 1'b0;
    waitq();
    rd(OFS_CAUSE2, 32'h0000_0001);
    ret(OFS_SAVED2, 32'h0000_0006, 1'b1);
    wr(OFS_SENS, 32'h0000_1000, RESP_OKAY);
    holdCompound <= 1'b1;
    fire(5'd12, 1'b1, 1'b0);
    repeat (6) @(posedge clk);
    rd(OFS_PENDING, 32'h0000_1000);
    expTake.push_back({1'b0, base + 32'h0000_0060});
    holdCompound <= 1'b0;
    waitq();
    rd(OFS_PENDING, 32'h0000_0000);
    ret(OFS_SAVED1, 32'h0000_0006, 1'b0);
    holdPredBranch <= 1'b1;
    hostTrigNum <= 5'd10;
    hostTrigValid <= 1'b1;
    @(posedge clk);
    hostTrigValid <= 1'b0;
    repeat (6) @(posedge clk);
    expTake.push_back({1'b0, base + 32'h0000_0050});
    holdPredBranch <= 1'b0;
    waitq();
    rd(OFS_CAUSE1, 32'h0000_000A);
    ret(OFS_SAVED1, 32'h0000_0006, 1'b0);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
